// >>> logic/uart_flow.sv
`timescale 1ns/100ps
`default_nettype none

module uart_flow
    import uart_flow_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset,
    input  wire logic [5:0]  i_address,
    input  wire logic        i_read,
    input  wire logic        i_write,
    input  wire logic [31:0] i_writedata,
    output logic      [31:0] o_readdata,
    output logic             o_waitrequest,
    input  wire logic        i_rxd,
    output logic             o_txd,
    input  wire logic        i_cts,
    output logic             o_rts,
    output logic             o_rts_oe,
    output logic             o_irq
);

    // ==========================================================
    // decoders
    function automatic logic hit(input logic [5:0] addr, input logic [5:0] ofs);
        return addr[5:2] == ofs[5:2];
    endfunction : hit

    function automatic logic [4:0] trig_level(input logic [1:0] sel);
        unique case (sel)
            2'h0: return 5'h01;
            2'h1: return 5'h04;
            2'h2: return 5'h08;
            2'h3: return 5'h0e;
        endcase
    endfunction : trig_level

    function automatic logic [4:0] rts_level(input logic [1:0] sel);
        unique case (sel)
            2'h0: return 5'h08;
            2'h1: return 5'h0b;
            2'h2: return 5'h0d;
            2'h3: return 5'h0f;
        endcase
    endfunction : rts_level

    // ==========================================================
    // declarations
    ctrl_s       ctrl_ff;
    irq_cfg_s    icfg_ff;
    logic [15:0] div_ff;
    logic        ack_ff;
    logic [31:0] rdata_ff;
    logic        tx_busy_ff;
    logic [3:0]  tx_cnt_ff;
    logic [8:0]  tx_shift_ff;
    logic        txd_ff;
    logic        txe_ff;
    logic        rx_busy_ff;
    logic [3:0]  rx_cnt_ff;
    logic [7:0]  rx_shift_ff;
    logic        ovr_ff;
    logic        cts_prev_ff;
    logic        cts_seen_ff;
    logic        msi_ff;
    logic [5:0]  to_cnt_ff;
    logic        rts_ff;
    logic        rts_oe_ff;
    logic [7:0]  tx_head;
    logic [7:0]  rx_head;
    logic [4:0]  tx_level;
    logic [4:0]  rx_level;
    logic        tx_full;
    logic        tx_empty;
    logic        rx_full;
    logic        rx_empty;
    logic        tx_tick;
    logic        rx_tick;

    // ==========================================================
    // avalon slave: one wait state, effects on the first edge
    wire strobe   = (i_read | i_write) & ~ack_ff;
    wire wr       = strobe & i_write;
    wire rd       = strobe & i_read;
    wire wr_data  = wr & hit(i_address, DATA_OFS);
    wire rd_data  = rd & hit(i_address, DATA_OFS);
    wire rd_line  = rd & hit(i_address, LINE_STATUS_OFS);
    wire rd_modem = rd & hit(i_address, MODEM_STATUS_OFS);
    wire rd_istat = rd & hit(i_address, IRQ_STATUS_OFS);
    assign o_waitrequest = strobe;
    assign o_readdata    = rdata_ff;

    // ==========================================================
    // flow-control view of the pins
    wire four_wire   = ctrl_ff.enable & ~ctrl_ff.two_wire;
    wire cts_active  = i_cts ^ ctrl_ff.active_low;
    wire auto_rx_on  = four_wire & ctrl_ff.auto_rx;
    wire auto_tx_on  = four_wire & ctrl_ff.auto_tx;
    wire cts_change  = cts_seen_ff & (i_cts != cts_prev_ff);
    wire rts_wanted  = auto_rx_on ? (rx_level < rts_level(ctrl_ff.auto_thr))
                                  : ctrl_ff.rts_manual;

    // ==========================================================
    // transmit path
    wire tx_push  = wr_data & ~tx_full;
    wire tx_gate  = ~auto_tx_on | cts_active;
    wire tx_free  = ~tx_busy_ff | (tx_cnt_ff == '0);
    wire tx_load  = tx_tick & tx_free & ~tx_empty & ctrl_ff.enable & tx_gate;
    wire tx_pop   = tx_load;
    wire txe_set  = tx_pop & (tx_level == 5'h01);

    // ==========================================================
    // receive path
    wire rx_start = ~rx_busy_ff & ~i_rxd & ctrl_ff.enable;
    wire rx_false = rx_tick & rx_busy_ff & (rx_cnt_ff == RX_FRAME_TICKS) & i_rxd;
    wire rx_done  = rx_tick & rx_busy_ff & (rx_cnt_ff == 4'h1);
    wire rx_push  = rx_done & ~rx_full;
    wire rx_pop   = rd_data & ~rx_empty;
    wire ovr_set  = rx_done & rx_full;

    // ==========================================================
    // interrupt conditions (levels gated by their enables)
    wire rxa_lvl     = (rx_level >= trig_level(icfg_ff.trig));
    wire timeout_lvl = (to_cnt_ff == TIMEOUT_TICKS) & ~rx_empty;
    assign o_irq = (icfg_ff.rxa_en & (rxa_lvl | timeout_lvl))
                 | (icfg_ff.txe_en & txe_ff)
                 | (icfg_ff.modem_en & msi_ff);

    // ==========================================================
    // read selection
    wire [31:0] line_word  = 32'(rx_empty ? 1'b0 : 1'b1) << LS_RX_READY_BIT
                           | 32'(ovr_ff) << LS_OVERRUN_BIT
                           | 32'(tx_empty) << LS_TX_EMPTY_BIT
                           | 32'(tx_empty & ~tx_busy_ff) << LS_TX_IDLE_BIT;
    wire [31:0] modem_word = 32'(msi_ff) << MS_CHANGE_BIT
                           | 32'(cts_active) << MS_CTS_BIT;
    wire [31:0] istat_word = 32'(rxa_lvl) << IS_RXA_BIT
                           | 32'(timeout_lvl) << IS_TIMEOUT_BIT
                           | 32'(txe_ff) << IS_TXE_BIT
                           | 32'(msi_ff) << IS_MODEM_BIT;
    wire [31:0] rd_mux =
        hit(i_address, DATA_OFS)         ? {24'h000000, rx_head} :
        hit(i_address, LINE_STATUS_OFS)  ? line_word :
        hit(i_address, MODEM_STATUS_OFS) ? modem_word :
        hit(i_address, TX_LEVEL_OFS)     ? {27'h0000000, tx_level} :
        hit(i_address, RX_LEVEL_OFS)     ? {27'h0000000, rx_level} :
        hit(i_address, CONTROL_OFS)      ? {24'h000000, ctrl_ff} :
        hit(i_address, IRQ_CONFIG_OFS)   ? {27'h0000000, icfg_ff} :
        hit(i_address, IRQ_STATUS_OFS)   ? istat_word :
        hit(i_address, DIVISOR_OFS)      ? {16'h0000, div_ff} : 32'h00000000;

    // ==========================================================
    // queues and bit-rate enables
    byte_queue #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) tx_q (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_push    (tx_push),
        .i_data    (i_writedata[7:0]),
        .i_pop     (tx_pop),
        .o_head    (tx_head),
        .o_level   (tx_level),
        .o_full    (tx_full),
        .o_empty   (tx_empty)
    );

    byte_queue #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rx_q (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_push    (rx_push),
        .i_data    (rx_shift_ff),
        .i_pop     (rx_pop),
        .o_head    (rx_head),
        .o_level   (rx_level),
        .o_full    (rx_full),
        .o_empty   (rx_empty)
    );

    bit_tick tx_rate (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_div     (div_ff),
        .i_restart (1'b0),
        .o_tick    (tx_tick)
    );

    bit_tick rx_rate (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_div     (div_ff),
        .i_restart (rx_start),
        .o_tick    (rx_tick)
    );

    // ==========================================================
    // bus handshake and registered read data
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            ack_ff   <= 1'b0;
            rdata_ff <= '0;
        end else begin
            ack_ff   <= strobe;
            rdata_ff <= rd ? rd_mux : rdata_ff;
        end
    end

    // software-written configuration
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            ctrl_ff <= CONTROL_RST;
            icfg_ff <= IRQ_CONFIG_RST;
            div_ff  <= DIVISOR_RST;
        end else begin
            if (wr & hit(i_address, CONTROL_OFS))
                ctrl_ff <= ctrl_s'(i_writedata[7:0]);
            if (wr & hit(i_address, IRQ_CONFIG_OFS))
                icfg_ff <= irq_cfg_s'(i_writedata[4:0]);
            if (wr & hit(i_address, DIVISOR_OFS))
                div_ff <= i_writedata[15:0];
        end
    end

    // transmit shifter: start bit on load, then 8 data and stop
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            tx_busy_ff  <= 1'b0;
            tx_cnt_ff   <= '0;
            tx_shift_ff <= '1;
            txd_ff      <= 1'b1;
        end else if (tx_tick) begin
            if (tx_busy_ff & (tx_cnt_ff != '0)) begin
                txd_ff      <= tx_shift_ff[0];
                tx_shift_ff <= {1'b1, tx_shift_ff[8:1]};
                tx_cnt_ff   <= tx_cnt_ff - 4'h1;
            end else if (tx_load) begin
                txd_ff      <= 1'b0;
                tx_shift_ff <= {1'b1, tx_head};
                tx_cnt_ff   <= TX_SHIFT_BITS;
                tx_busy_ff  <= 1'b1;
            end else begin
                tx_busy_ff  <= 1'b0;
                txd_ff      <= 1'b1;
            end
        end
    end
    assign o_txd = txd_ff;

    // receive sampler: mid-bit samples, start check then 8 data then stop
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            rx_busy_ff  <= 1'b0;
            rx_cnt_ff   <= '0;
            rx_shift_ff <= '0;
        end else if (rx_start) begin
            rx_busy_ff <= 1'b1;
            rx_cnt_ff  <= RX_FRAME_TICKS;
        end else if (rx_false | rx_done) begin
            rx_busy_ff <= 1'b0;
        end else if (rx_tick & rx_busy_ff) begin
            rx_cnt_ff <= rx_cnt_ff - 4'h1;
            if (rx_cnt_ff != RX_FRAME_TICKS)
                rx_shift_ff <= {i_rxd, rx_shift_ff[7:1]};
        end
    end

    // sticky flags: a set in the clearing cycle wins
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            txe_ff      <= 1'b0;
            ovr_ff      <= 1'b0;
            msi_ff      <= 1'b0;
            cts_prev_ff <= 1'b0;
            cts_seen_ff <= 1'b0;
        end else begin
            txe_ff      <= txe_set | (txe_ff & ~rd_istat & ~tx_push);
            ovr_ff      <= ovr_set | (ovr_ff & ~rd_line);
            msi_ff      <= cts_change | (msi_ff & ~rd_modem);
            cts_prev_ff <= i_cts;
            cts_seen_ff <= 1'b1;
        end
    end

    // receive timeout: four character times without push or pop
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            to_cnt_ff <= '0;
        end else if (rx_push | rx_pop | rx_empty) begin
            to_cnt_ff <= '0;
        end else if (tx_tick & (to_cnt_ff != TIMEOUT_TICKS)) begin
            to_cnt_ff <= to_cnt_ff + 6'h01;
        end
    end

    // request pin and ownership, refreshed every cycle
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            rts_ff    <= 1'b0;
            rts_oe_ff <= 1'b0;
        end else begin
            rts_ff    <= rts_wanted ^ ctrl_ff.active_low;
            rts_oe_ff <= four_wire;
        end
    end
    assign o_rts    = rts_ff;
    assign o_rts_oe = rts_oe_ff;

    // ==========================================================
    // checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    a_tx_full_drop: assert property (wr_data & tx_full & ~tx_pop |=> tx_level == 5'h10)
        else $error("write into full transmit queue changed level");
    a_tx_start_bit: assert property (tx_load |=> ~o_txd & (tx_shift_ff == {1'b1, $past(tx_head)}))
        else $error("start bit or first data bit missing");
    a_tx_empty_flag: assert property (tx_pop & ~tx_push & (tx_level == 5'h01) |=> txe_ff & tx_empty)
        else $error("transmit-empty flag not set on last byte");
    a_rts_released: assert property (ctrl_ff.two_wire |=> ~o_rts_oe)
        else $error("request pin driven in 2-wire mode");
    a_rts_auto_level: assert property (auto_rx_on
        |=> (o_rts ^ $past(ctrl_ff.active_low)) == ($past(rx_level) < rts_level($past(ctrl_ff.auto_thr))))
        else $error("auto request line disagrees with fill level");
    a_cts_gates_tx: assert property (auto_tx_on & ~cts_active |-> ~tx_load)
        else $error("byte started while clear-to-send inactive");
    a_modem_change: assert property (cts_change |=> msi_ff ##0 (o_irq | ~icfg_ff.modem_en))
        else $error("clear-to-send change not flagged");
    a_rx_overrun: assert property (rx_done & rx_full & ~rx_pop |=> ovr_ff & (rx_level == 5'h10))
        else $error("overrun not flagged or byte stored");
    a_timeout_hold: assert property (timeout_lvl |-> (rx_level != '0) & (to_cnt_ff == TIMEOUT_TICKS))
        else $error("timeout with empty queue");
    a_bus_one_wait: assert property (strobe |=> ~o_waitrequest)
        else $error("bus answer took more than one wait state");

endmodule : uart_flow

`default_nettype wire

// >>> logic/uart_flow_pkg.sv
package uart_flow_pkg;

    // ==========================================================
    // register map (byte addresses, one 32-bit word each)
    localparam logic [5:0] DATA_OFS        = 6'h00;
    localparam logic [5:0] LINE_STATUS_OFS = 6'h04;
    localparam logic [5:0] MODEM_STATUS_OFS = 6'h08;
    localparam logic [5:0] TX_LEVEL_OFS    = 6'h0c;
    localparam logic [5:0] RX_LEVEL_OFS    = 6'h10;
    localparam logic [5:0] CONTROL_OFS     = 6'h14;
    localparam logic [5:0] IRQ_CONFIG_OFS  = 6'h18;
    localparam logic [5:0] IRQ_STATUS_OFS  = 6'h1c;
    localparam logic [5:0] DIVISOR_OFS     = 6'h20;

    // ==========================================================
    // field positions
    localparam int LS_RX_READY_BIT = 0;
    localparam int LS_OVERRUN_BIT  = 1;
    localparam int LS_TX_EMPTY_BIT = 5;
    localparam int LS_TX_IDLE_BIT  = 6;
    localparam int MS_CHANGE_BIT   = 0;
    localparam int MS_CTS_BIT      = 4;
    localparam int IS_RXA_BIT      = 0;
    localparam int IS_TIMEOUT_BIT  = 1;
    localparam int IS_TXE_BIT      = 2;
    localparam int IS_MODEM_BIT    = 3;

    // ==========================================================
    // control word: bit0 enable ... bit7 active-low pins
    typedef struct packed {
        logic       active_low;
        logic [1:0] auto_thr;
        logic       auto_tx;
        logic       auto_rx;
        logic       rts_manual;
        logic       two_wire;
        logic       enable;
    } ctrl_s;

    typedef struct packed {
        logic [1:0] trig;
        logic       modem_en;
        logic       txe_en;
        logic       rxa_en;
    } irq_cfg_s;

    // ==========================================================
    // reset values and timing
    localparam ctrl_s       CONTROL_RST    = '0;
    localparam irq_cfg_s    IRQ_CONFIG_RST = '0;
    localparam logic [15:0] DIVISOR_RST    = 16'h0364;
    localparam int          FIFO_DEPTH     = 16;
    localparam int          CHAR_BITS      = 10;
    localparam int          TIMEOUT_CHARS  = 4;
    localparam logic [5:0]  TIMEOUT_TICKS  = 6'(TIMEOUT_CHARS * CHAR_BITS);
    localparam logic [3:0]  TX_SHIFT_BITS  = 4'h9;
    localparam logic [3:0]  RX_FRAME_TICKS = 4'ha;

endpackage : uart_flow_pkg

// >>> logic/byte_queue.sv
`timescale 1ns/100ps
`default_nettype none

module byte_queue #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int LW    = $clog2(DEPTH) + 1
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_reset,
    input  wire logic             i_push,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_pop,
    output logic      [WIDTH-1:0] o_head,
    output logic      [LW-1:0]    o_level,
    output logic                  o_full,
    output logic                  o_empty
);

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr_ff;
    logic [PW-1:0]    rd_ptr_ff;
    logic [LW-1:0]    level_ff;
    wire              do_push = i_push & ~o_full;
    wire              do_pop  = i_pop & ~o_empty;

    // ==========================================================
    // status
    assign o_full  = (level_ff == LW'(DEPTH));
    assign o_empty = (level_ff == '0);
    assign o_level = level_ff;
    assign o_head  = mem[rd_ptr_ff];

    // storage array
    always_ff @(posedge i_ref_clk) begin
        if (do_push) begin
            mem[wr_ptr_ff] <= i_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            level_ff  <= '0;
        end else begin
            wr_ptr_ff <= wr_ptr_ff + PW'(do_push);
            rd_ptr_ff <= rd_ptr_ff + PW'(do_pop);
            level_ff  <= level_ff + LW'(do_push) - LW'(do_pop);
        end
    end

endmodule : byte_queue

`default_nettype wire

// >>> logic/bit_tick.sv
`timescale 1ns/100ps
`default_nettype none

module bit_tick (
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset,
    input  wire logic [15:0] i_div,
    input  wire logic        i_restart,
    output logic             o_tick
);

    logic [15:0] cnt_ff;

    // ==========================================================
    // one-cycle enable every i_div clocks; restart aims mid-bit
    assign o_tick = (cnt_ff == '0) & ~i_restart;

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            cnt_ff <= '0;
        end else if (i_restart) begin
            cnt_ff <= {1'b0, i_div[15:1]};
        end else if (cnt_ff == '0) begin
            cnt_ff <= i_div - 16'h0001;
        end else begin
            cnt_ff <= cnt_ff - 16'h0001;
        end
    end

endmodule : bit_tick

`default_nettype wire

// >>> verif/remote_uart.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// far end: 8N1 serial at 4 clocks a bit
module remote_uart (
    input  wire logic i_ref_clk,
    input  wire logic i_line,
    output logic      o_line,
    output logic      o_ready
);
    logic [7:0] got_q[$];
    logic [7:0] b;
    // idle line high, ready to take data
    initial begin
        o_line = 1'b1;
        o_ready = 1'b1;
    end
    // receiver samples mid-bit, away from the design's edge
    initial begin
        forever begin
            @(negedge i_ref_clk);
            if (i_line === 1'b0) begin
                repeat (2) @(negedge i_ref_clk);
                for (int i = 0; i < 8; i++) begin
                    repeat (4) @(negedge i_ref_clk);
                    b[i] = i_line;
                end
                repeat (4) @(negedge i_ref_clk);
                got_q.push_back(b);
            end
        end
    end
    // sender: start bit, data low bit first, stop bit
    task automatic send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge i_ref_clk);
            o_line <= f[i];
            repeat (3) @(posedge i_ref_clk);
        end
    endtask : send
    // request line of the far end, seen as clear-to-send here
    task automatic set_ready(input logic v);
        @(posedge i_ref_clk);
        o_ready <= v;
    endtask : set_ready
endmodule : remote_uart
`default_nettype wire

// >>> verif/uart_fifo_flow_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// bench for queues and flow control
module uart_fifo_flow_control_bench
    import uart_flow_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        reset   = 1'b1;
    logic        read    = 1'b0;
    logic        write   = 1'b0;
    logic [5:0]  address = 6'h00;
    logic [31:0] wdata   = 32'h0;
    logic [31:0] rdata, rd_s, got;
    logic        waitreq, wr_s, txd, rxd, cts, rts, rts_oe, irq;
    int          fail_count = 0;
    int          n_tests    = 0;

    // clock and settled copies of the bus answer
    always #5 ref_clk = ~ref_clk;
    always @(negedge ref_clk) begin
        wr_s = waitreq;
        rd_s = rdata;
    end

    uart_flow uart_flow_inst (.i_ref_clk(ref_clk), .i_reset(reset), .i_address(address), .i_read(read),
        .i_write(write), .i_writedata(wdata), .o_readdata(rdata), .o_waitrequest(waitreq), .i_rxd(rxd),
        .o_txd(txd), .i_cts(cts), .o_rts(rts), .o_rts_oe(rts_oe), .o_irq(irq));
    remote_uart remote_uart_inst (.i_ref_clk(ref_clk), .i_line(txd), .o_line(rxd), .o_ready(cts));

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop
    // one bus transfer, held until waitrequest is seen low
    task automatic bus(input logic is_rd, input logic [5:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        read <= is_rd;
        write <= !is_rd;
        address <= a;
        wdata <= d;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wr_s !== 1'b0 && n < 20);
        check(32'(n < 20), 32'h1);
        if (n >= 20) report_and_stop();
        got = rd_s;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b0, a, d);
    endtask : wr
    task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
        bus(1'b1, a, 32'h0);
        check(got, e);
    endtask : rd_chk
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : idle
    // bounded wait for frames at the far end
    task automatic wait_got(input int n);
        int k;
        k = 0;
        while (remote_uart_inst.got_q.size() < n && k < 3000) begin
            @(posedge ref_clk);
            k++;
        end
        check(32'(k < 3000), 32'h1);
        if (k >= 3000) report_and_stop();
    endtask : wait_got

    task automatic t_reset();
        check(32'(rts_oe), 32'h0);
        rd_chk(CONTROL_OFS, 32'h0);
        rd_chk(DIVISOR_OFS, 32'h364);
        rd_chk(6'h3c, 32'h0);
        wr(DIVISOR_OFS, 32'h4);
        wr(CONTROL_OFS, 32'h1);
        idle(2);
        check(32'(rts_oe), 32'h1);
    endtask : t_reset
    task automatic t_manual();
        wr(CONTROL_OFS, 32'h5);
        idle(2);
        check(32'(rts), 32'h1);
        rd_chk(MODEM_STATUS_OFS, 32'h10);
        wr(CONTROL_OFS, 32'h85);
        idle(2);
        check(32'(rts), 32'h0);
        rd_chk(MODEM_STATUS_OFS, 32'h0);
    endtask : t_manual
    // transmit held by clear-to-send, then drained in order
    task automatic t_tx();
        remote_uart_inst.set_ready(1'b0);
        wr(CONTROL_OFS, 32'h11);
        wr(IRQ_CONFIG_OFS, 32'h2);
        rd_chk(MODEM_STATUS_OFS, 32'h1);
        for (int i = 0; i < 17; i++) begin
            wr(DATA_OFS, 32'(i));
        end
        idle(1000);
        rd_chk(TX_LEVEL_OFS, 32'h10);
        bus(1'b1, LINE_STATUS_OFS, 32'h0);
        check(got & 32'h20, 32'h0);
        check(32'(remote_uart_inst.got_q.size()), 32'h0);
        remote_uart_inst.set_ready(1'b1);
        idle(4);
        rd_chk(MODEM_STATUS_OFS, 32'h11);
        wait_got(16);
        for (int i = 0; i < 16; i++) begin
            check(32'(remote_uart_inst.got_q[i]), 32'(i));
        end
        idle(20);
        check(32'(irq), 32'h1);
        bus(1'b1, LINE_STATUS_OFS, 32'h0);
        check(got & 32'h20, 32'h20);
        rd_chk(TX_LEVEL_OFS, 32'h0);
        wr(IRQ_CONFIG_OFS, 32'h0);
    endtask : t_tx
    // receive up to the request threshold, then read back
    task automatic t_rx();
        wr(CONTROL_OFS, 32'h9);
        wr(IRQ_CONFIG_OFS, 32'h1);
        idle(2);
        check(32'(rts), 32'h1);
        for (int i = 0; i < 8; i++) begin
            remote_uart_inst.send(8'h40 + 8'(i));
        end
        idle(6);
        check(32'(rts), 32'h0);
        check(32'(irq), 32'h1);
        rd_chk(RX_LEVEL_OFS, 32'h8);
        bus(1'b1, LINE_STATUS_OFS, 32'h0);
        check(got & 32'h1, 32'h1);
        for (int i = 0; i < 8; i++) begin
            rd_chk(DATA_OFS, 32'h40 + 32'(i));
            idle(1);
            check(32'(rts), 32'h1);
        end
        check(32'(irq), 32'h0);
        remote_uart_inst.send(8'h5a);
        idle(120);
        bus(1'b1, IRQ_STATUS_OFS, 32'h0);
        check(got & 32'h2, 32'h0);
        idle(60);
        bus(1'b1, IRQ_STATUS_OFS, 32'h0);
        check(got & 32'h2, 32'h2);
        rd_chk(DATA_OFS, 32'h5a);
        rd_chk(RX_LEVEL_OFS, 32'h0);
    endtask : t_rx
    // receive queue overfilled: extra byte dropped, overrun flagged
    task automatic t_overrun();
        for (int i = 0; i < 17; i++) begin
            remote_uart_inst.send(8'(i));
        end
        idle(6);
        rd_chk(RX_LEVEL_OFS, 32'h10);
        bus(1'b1, LINE_STATUS_OFS, 32'h0);
        check(got & 32'h3, 32'h3);
        bus(1'b1, LINE_STATUS_OFS, 32'h0);
        check(got & 32'h2, 32'h0);
        for (int i = 0; i < 16; i++) begin
            rd_chk(DATA_OFS, 32'(i));
        end
    endtask : t_overrun
    // two-wire: pins released, clear-to-send ignored
    task automatic t_two_wire();
        remote_uart_inst.set_ready(1'b0);
        wr(CONTROL_OFS, 32'h13);
        idle(2);
        check(32'(rts_oe), 32'h0);
        wr(DATA_OFS, 32'h3c);
        wait_got(17);
        check(32'(remote_uart_inst.got_q[16]), 32'h3c);
    endtask : t_two_wire

    // main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        t_manual();
        t_tx();
        t_rx();
        t_overrun();
        t_two_wire();
        report_and_stop();
    end
endmodule : uart_fifo_flow_control_bench
`default_nettype wire
